// ==== slq_sequencer.sv ====
// Setpoint list sequencer: command decode, list playback, status groups.
// Assumes one clock, synchronous reset and a plain register port whose
// read data appear in the cycle after the read strobe.
//
// Functional notes
// - Store at most 1002 volatile entries.
// - Entry pairs setpoint with dwell time.
// - Refuse list edits while sequence runs.
// - Fixed-mode command halts, output holds.
// - Entries survive runs until clear.
// - New entries append after existing ones.
// - One dwell for all, else one each.
// - Repeat count zero runs without limit.
// - Count 1..255 decrements, then fixed mode.
// - List-mode starts, fixed-mode command ends.
// - Reset stops list, output off, voltage.
// - Skipped leading entries run first pass only.
// - Direction selects forward or reversed playback.
// - Points query returns stored entry count.
// - Optional controller order may repeat entries.
// - Operation, questionable groups: condition, enable, event.
// - Output state command enables channel output.
// - LF, CR or both end a message.
//
// Our own choices: the strobed register port and the register offsets.
module slq_sequencer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [slq_pkg::ADDR_W-1:0] addr,
  input wire logic [slq_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [slq_pkg::DATA_W-1:0] rdata,
  output logic [slq_pkg::SP_W-1:0] out_setpoint,
  output logic out_is_current,
  output logic out_enable,
  output logic list_running,
  output logic oper_summary,
  output logic ques_summary
);
  // ==========================================================================
  // Declarations
  localparam logic [slq_pkg::IDX_W-1:0] IDX_ONE_L = slq_pkg::IDX_ONE;
  slq_pkg::slq_state_t state;
  slq_mem_if mem ();
  logic [3:0] cmd;
  logic cmd_wr, is_start, is_fix, is_reset, edit_wr, edit_ok, refused;
  logic running, tmr_load, tmr_done, first_pass, dir_rev, prev_term, is_term;
  logic [slq_pkg::IDX_W-1:0] points, dw_cnt, ord_len, len, pos, pos_idx;
  logic [slq_pkg::IDX_W-1:0] skip, skip_eff, entry;
  logic [slq_pkg::CNT_W-1:0] count, remaining;
  logic [slq_pkg::DATA_W-1:0] msg_cnt;
  logic [slq_pkg::STAT_W-1:0] cond [2];
  logic [slq_pkg::STAT_W-1:0] cond_q [2];
  logic [slq_pkg::STAT_W-1:0] enab [2];
  logic [slq_pkg::STAT_W-1:0] evt [2];
  logic [slq_pkg::STAT_W-1:0] extra [2];
  logic [1:0] evt_clr;

  slq_store u_store (
    .clk_sys(clk_sys),
    .mem(mem)
  );

  slq_dwell_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(tmr_load),
    .load_val(mem.dw_rdata),
    .abort(state == slq_pkg::SLQ_IDLE),
    .done(tmr_done)
  );

  // ==========================================================================
  // Command decode
  assign cmd = wdata[3:0];
  assign cmd_wr = wr && (addr == slq_pkg::ADDR_CMD);
  assign is_start = cmd_wr && (cmd == slq_pkg::CMD_LIST_VOLT ||
    cmd == slq_pkg::CMD_LIST_CURR);
  assign is_fix = cmd_wr && (cmd == slq_pkg::CMD_FIX_VOLT ||
    cmd == slq_pkg::CMD_FIX_CURR);
  assign is_reset = cmd_wr && (cmd == slq_pkg::CMD_RESET);
  assign running = (state != slq_pkg::SLQ_IDLE);
  assign edit_wr = (wr && addr >= slq_pkg::ADDR_LIST_VOLT &&
    addr <= slq_pkg::ADDR_ORDER) || (cmd_wr && cmd == slq_pkg::CMD_CLEAR);
  assign refused = edit_wr && running;
  assign edit_ok = edit_wr && !running;

  // ==========================================================================
  // Playback addressing
  assign len = (ord_len != '0) ? ord_len : points;
  assign skip_eff = (skip < len) ? skip : '0;
  assign pos_idx = dir_rev ? (len - IDX_ONE_L - pos) : pos;
  assign entry = (ord_len != '0) ? mem.ord_rdata : pos_idx;
  assign mem.ord_raddr = pos_idx;
  assign mem.ent_raddr = entry;
  assign mem.dw_raddr = (dw_cnt == IDX_ONE_L) ? '0 : entry;
  assign tmr_load = (state == slq_pkg::SLQ_LOAD);


  // ==========================================================================
  // Sequencer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= slq_pkg::SLQ_IDLE;
      pos <= '0;
      first_pass <= 1'b1;
      remaining <= '0;
      out_setpoint <= '0;
      out_is_current <= 1'b0;
    end
    else if (is_reset)
    begin
      state <= slq_pkg::SLQ_IDLE;
      out_is_current <= 1'b0;
    end
    else if (is_fix)
    begin
      state <= slq_pkg::SLQ_IDLE;
      out_is_current <= (cmd == slq_pkg::CMD_FIX_CURR);
    end
    else if (is_start && !running && len != '0 && dw_cnt != '0)
    begin
      state <= slq_pkg::SLQ_LOAD;
      out_is_current <= (cmd == slq_pkg::CMD_LIST_CURR);
      pos <= '0;
      first_pass <= 1'b1;
      remaining <= count;
    end
    else
    begin
      unique case (state)
        slq_pkg::SLQ_IDLE:
        begin
        end
        slq_pkg::SLQ_LOAD:
        begin
          out_setpoint <= mem.sp_rdata;
          state <= slq_pkg::SLQ_DWELL;
        end
        slq_pkg::SLQ_DWELL:
        begin
          if (tmr_done)
          begin
            if (pos != len - IDX_ONE_L)
            begin
              pos <= pos + IDX_ONE_L;
              state <= slq_pkg::SLQ_LOAD;
            end
            else if (count == '0 || remaining > 8'h01)
            begin
              // Zero count never decrements, so the list loops forever.
              if (count != '0)
              begin
                remaining <= remaining - 8'h01;
              end
              first_pass <= 1'b0;
              pos <= skip_eff;
              state <= slq_pkg::SLQ_LOAD;
            end
            else
            begin
              remaining <= '0;
              state <= slq_pkg::SLQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign list_running = running;

  // ==========================================================================
  // Output state
  always_ff @(posedge clk_sys)
  begin
    if (rst || is_reset)
    begin
      out_enable <= 1'b0;
    end
    else if (cmd_wr && cmd == slq_pkg::CMD_OUT_ON)
    begin
      out_enable <= 1'b1;
    end
    else if (cmd_wr && cmd == slq_pkg::CMD_OUT_OFF)
    begin
      out_enable <= 1'b0;
    end
  end

  // ==========================================================================
  // List storage and settings
  assign mem.sp_we = edit_ok && points < slq_pkg::IDX_MAX &&
    (addr == slq_pkg::ADDR_LIST_VOLT || addr == slq_pkg::ADDR_LIST_CURR);
  assign mem.sp_waddr = points;
  assign mem.sp_wdata = wdata;
  assign mem.dw_we = edit_ok && addr == slq_pkg::ADDR_DWELL &&
    dw_cnt < slq_pkg::IDX_MAX;
  assign mem.dw_waddr = dw_cnt;
  assign mem.dw_wdata = wdata;
  assign mem.ord_we = edit_ok && addr == slq_pkg::ADDR_ORDER &&
    ord_len < slq_pkg::IDX_MAX;
  assign mem.ord_waddr = ord_len;
  assign mem.ord_wdata = wdata[slq_pkg::IDX_W-1:0];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      points <= '0;
      dw_cnt <= '0;
      ord_len <= '0;
      count <= slq_pkg::RST_COUNT;
      skip <= '0;
      dir_rev <= 1'b0;
    end
    else if (edit_ok && cmd_wr)
    begin
      points <= '0;
      dw_cnt <= '0;
      ord_len <= '0;
    end
    else if (edit_ok)
    begin
      if (mem.sp_we)
      begin
        points <= points + IDX_ONE_L;
      end
      if (mem.dw_we)
      begin
        dw_cnt <= dw_cnt + IDX_ONE_L;
      end
      if (mem.ord_we)
      begin
        ord_len <= ord_len + IDX_ONE_L;
      end
      if (addr == slq_pkg::ADDR_COUNT)
      begin
        count <= wdata[slq_pkg::CNT_W-1:0];
      end
      if (addr == slq_pkg::ADDR_SKIP)
      begin
        skip <= wdata[slq_pkg::IDX_W-1:0];
      end
      if (addr == slq_pkg::ADDR_DIR)
      begin
        dir_rev <= wdata[0];
      end
    end
  end

  // ==========================================================================
  // Message terminators
  assign is_term = wdata[7:0] == slq_pkg::CHAR_LF ||
    wdata[7:0] == slq_pkg::CHAR_CR;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      msg_cnt <= '0;
      prev_term <= 1'b0;
    end
    else if (wr && addr == slq_pkg::ADDR_TERM)
    begin
      if (is_term && !prev_term)
      begin
        msg_cnt <= msg_cnt + 16'h0001;
      end
      prev_term <= is_term;
    end
  end

  // ==========================================================================
  // Status groups; a hardware set wins over a clear by read.
  assign cond[0] = {5'h00, out_is_current, out_enable, running};
  assign cond[1] = {5'h00, dw_cnt > IDX_ONE_L && dw_cnt != points,
    points == slq_pkg::IDX_MAX, points == '0};
  assign extra[0] = '0;
  assign extra[1] = {refused, 7'h00};
  assign evt_clr[0] = rd && addr == slq_pkg::ADDR_OPER_EVT;
  assign evt_clr[1] = rd && addr == slq_pkg::ADDR_QUES_EVT;

  for (genvar g = 0; g < 2; g++)
  begin : g_stat
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        cond_q[g] <= '0;
        enab[g] <= '0;
        evt[g] <= '0;
      end
      else
      begin
        cond_q[g] <= cond[g];
        evt[g] <= (evt[g] & {slq_pkg::STAT_W{!evt_clr[g]}}) |
          (cond[g] & ~cond_q[g]) | extra[g];
        if (wr && addr == (g == 0 ? slq_pkg::ADDR_OPER_ENAB :
          slq_pkg::ADDR_QUES_ENAB))
        begin
          enab[g] <= wdata[slq_pkg::STAT_W-1:0];
        end
      end
    end
  end

  assign oper_summary = |(evt[0] & enab[0]);
  assign ques_summary = |(evt[1] & enab[1]);

  // ==========================================================================
  // Register read port
  always_ff @(posedge clk_sys)
  begin
    rdata <= '0;
    if (!rst && rd)
    begin
      unique case (addr)
        slq_pkg::ADDR_CMD: rdata <= {13'h0000, out_is_current, out_enable,
          running};
        slq_pkg::ADDR_LIST_VOLT, slq_pkg::ADDR_LIST_CURR:
          rdata <= {6'h00, points};
        slq_pkg::ADDR_DWELL: rdata <= {6'h00, dw_cnt};
        slq_pkg::ADDR_COUNT: rdata <= {8'h00, count};
        slq_pkg::ADDR_SKIP: rdata <= {6'h00, skip};
        slq_pkg::ADDR_DIR: rdata <= {15'h0000, dir_rev};
        slq_pkg::ADDR_ORDER: rdata <= {6'h00, ord_len};
        slq_pkg::ADDR_OPER_COND: rdata <= {8'h00, cond[0]};
        slq_pkg::ADDR_OPER_ENAB: rdata <= {8'h00, enab[0]};
        slq_pkg::ADDR_OPER_EVT: rdata <= {8'h00, evt[0]};
        slq_pkg::ADDR_QUES_COND: rdata <= {8'h00, cond[1]};
        slq_pkg::ADDR_QUES_ENAB: rdata <= {8'h00, enab[1]};
        slq_pkg::ADDR_QUES_EVT: rdata <= {8'h00, evt[1]};
        slq_pkg::ADDR_TERM: rdata <= msg_cnt;
        slq_pkg::ADDR_SETPOINT: rdata <= out_setpoint;
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_cap; points <= slq_pkg::IDX_MAX; endproperty
  a_cap: assert property (p_cap) else $error("list over capacity");
  property p_refuse; refused |=> $stable(points) && $stable(count);
  endproperty
  a_refuse: assert property (p_refuse) else $error("edit taken in run");
  property p_fix; is_fix |=> !running && $stable(out_setpoint); endproperty
  a_fix: assert property (p_fix) else $error("fixed cmd did not halt");
  property p_keep; $fell(running) |-> $stable(points); endproperty
  a_keep: assert property (p_keep) else $error("stop lost entries");
  property p_append; mem.sp_we |=> points == $past(points) + IDX_ONE_L;
  endproperty
  a_append: assert property (p_append) else $error("append miscount");
  property p_loop; running && count == '0 && !cmd_wr |=> running; endproperty
  a_loop: assert property (p_loop) else $error("endless list stopped");
  property p_last; state == slq_pkg::SLQ_DWELL && tmr_done && count != '0 &&
    remaining == 8'h01 && pos == len - IDX_ONE_L && !cmd_wr |=> !running;
  endproperty
  a_last: assert property (p_last) else $error("count end missed");
  property p_start; $rose(running) |-> $past(is_start); endproperty
  a_start: assert property (p_start) else $error("run without start");
  property p_reset; is_reset |=> !out_enable && !out_is_current && !running;
  endproperty
  a_reset: assert property (p_reset) else $error("reset cmd ignored");
  property p_points; rd && addr == slq_pkg::ADDR_LIST_VOLT && !wr |=>
    rdata == {6'h00, $past(points)}; endproperty
  a_points: assert property (p_points) else $error("points read wrong");
  property p_term2; wr && addr == slq_pkg::ADDR_TERM && is_term ##1
    wr && addr == slq_pkg::ADDR_TERM && is_term |=> $stable(msg_cnt);
  endproperty
  a_term2: assert property (p_term2) else $error("second term counted");

  c_run: cover property (is_start ##[1:8] running);
  c_fix: cover property (running ##1 is_fix);
  c_pass: cover property (running && !first_pass);
  c_refuse: cover property (refused);
endmodule : slq_sequencer

// ==== slq_pkg.sv ====
// Constants, register map and types of the setpoint list sequencer.
// Assumes one 40 MHz clock and a plain register port with index addresses.
package slq_pkg;

  // ==========================================================================
  // Sizes
  localparam int MAX_POINTS = 1002;
  localparam int IDX_W = 10;
  localparam int SP_W = 16;
  localparam int DW_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int STAT_W = 8;
  localparam int CNT_W = 8;
  localparam logic [IDX_W-1:0] IDX_ONE = 10'h001;
  localparam logic [IDX_W-1:0] IDX_MAX = 10'h3EA;

  // ==========================================================================
  // Register indices
  localparam logic [ADDR_W-1:0] ADDR_CMD = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_LIST_VOLT = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_LIST_CURR = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_DWELL = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_SKIP = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_DIR = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_ORDER = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_OPER_COND = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_OPER_ENAB = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_OPER_EVT = 4'hA;
  localparam logic [ADDR_W-1:0] ADDR_QUES_COND = 4'hB;
  localparam logic [ADDR_W-1:0] ADDR_QUES_ENAB = 4'hC;
  localparam logic [ADDR_W-1:0] ADDR_QUES_EVT = 4'hD;
  localparam logic [ADDR_W-1:0] ADDR_TERM = 4'hE;
  localparam logic [ADDR_W-1:0] ADDR_SETPOINT = 4'hF;

  // ==========================================================================
  // Command codes written to the command register
  localparam logic [3:0] CMD_CLEAR = 4'h1;
  localparam logic [3:0] CMD_LIST_VOLT = 4'h2;
  localparam logic [3:0] CMD_LIST_CURR = 4'h3;
  localparam logic [3:0] CMD_FIX_VOLT = 4'h4;
  localparam logic [3:0] CMD_FIX_CURR = 4'h5;
  localparam logic [3:0] CMD_RESET = 4'h6;
  localparam logic [3:0] CMD_OUT_ON = 4'h7;
  localparam logic [3:0] CMD_OUT_OFF = 4'h8;

  // ==========================================================================
  // Reset values, characters and timing
  localparam logic [CNT_W-1:0] RST_COUNT = 8'h01;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 6;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  typedef enum logic [1:0] {SLQ_IDLE, SLQ_LOAD, SLQ_DWELL} slq_state_t;

endpackage : slq_pkg

// ==== slq_mem_if.sv ====
// Interface between the sequencer and its entry store.
// Assumes writes and reads share the system clock.
interface slq_mem_if;
  logic sp_we;
  logic [slq_pkg::IDX_W-1:0] sp_waddr;
  logic [slq_pkg::SP_W-1:0] sp_wdata;
  logic dw_we;
  logic [slq_pkg::IDX_W-1:0] dw_waddr;
  logic [slq_pkg::DW_W-1:0] dw_wdata;
  logic ord_we;
  logic [slq_pkg::IDX_W-1:0] ord_waddr;
  logic [slq_pkg::IDX_W-1:0] ord_wdata;
  logic [slq_pkg::IDX_W-1:0] ord_raddr;
  logic [slq_pkg::IDX_W-1:0] ord_rdata;
  logic [slq_pkg::IDX_W-1:0] ent_raddr;
  logic [slq_pkg::IDX_W-1:0] dw_raddr;
  logic [slq_pkg::SP_W-1:0] sp_rdata;
  logic [slq_pkg::DW_W-1:0] dw_rdata;
  modport store (input sp_we, sp_waddr, sp_wdata, dw_we, dw_waddr, dw_wdata,
    ord_we, ord_waddr, ord_wdata, ord_raddr, ent_raddr, dw_raddr,
    output ord_rdata, sp_rdata, dw_rdata);
  modport ctrl (output sp_we, sp_waddr, sp_wdata, dw_we, dw_waddr, dw_wdata,
    ord_we, ord_waddr, ord_wdata, ord_raddr, ent_raddr, dw_raddr,
    input ord_rdata, sp_rdata, dw_rdata);
endinterface : slq_mem_if

// ==== slq_store.sv ====
// Entry store: setpoints, dwell values and the execution order table.
// Assumes the controller keeps every write address below the capacity.
module slq_store (
  input wire logic clk_sys,
  slq_mem_if.store mem
);
  // Volatile only; contents are undefined until written.
  logic [slq_pkg::SP_W-1:0] sp_mem [slq_pkg::MAX_POINTS];
  logic [slq_pkg::DW_W-1:0] dw_mem [slq_pkg::MAX_POINTS];
  logic [slq_pkg::IDX_W-1:0] ord_mem [slq_pkg::MAX_POINTS];

  always_ff @(posedge clk_sys)
  begin
    if (mem.sp_we)
    begin
      sp_mem[mem.sp_waddr] <= mem.sp_wdata;
    end
    if (mem.dw_we)
    begin
      dw_mem[mem.dw_waddr] <= mem.dw_wdata;
    end
    if (mem.ord_we)
    begin
      ord_mem[mem.ord_waddr] <= mem.ord_wdata;
    end
  end

  assign mem.sp_rdata = sp_mem[mem.ent_raddr];
  assign mem.dw_rdata = dw_mem[mem.dw_raddr];
  assign mem.ord_rdata = ord_mem[mem.ord_raddr];
endmodule : slq_store

// ==== slq_dwell_timer.sv ====
// Dwell timer counting in ticks of a 1 us time base.
// Assumes load is a one-cycle pulse and abort may be held.
module slq_dwell_timer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [slq_pkg::DW_W-1:0] load_val,
  input wire logic abort,
  output logic done
);
  logic [slq_pkg::TICK_W-1:0] div;
  logic tick;
  logic [slq_pkg::DW_W-1:0] cnt;
  logic busy;

  assign tick = (div == slq_pkg::TICK_LAST);

  // The base runs free, so the first tick of a dwell comes early by up to
  // one tick; this keeps the divider shared and cheap.
  always_ff @(posedge clk_sys)
  begin
    if (rst || tick)
    begin
      div <= '0;
    end
    else
    begin
      div <= div + 6'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    done <= 1'b0;
    if (rst || abort)
    begin
      busy <= 1'b0;
      cnt <= '0;
    end
    else if (load)
    begin
      busy <= 1'b1;
      cnt <= load_val;
    end
    else if (busy && tick)
    begin
      if (cnt <= 16'h0001)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      else
      begin
        cnt <= cnt - 16'h0001;
      end
    end
  end
endmodule : slq_dwell_timer

// ==== slq_ctrl_model.sv ====
// Controller model: issues register writes and reads to the sequencer.
// Assumes the bench calls its tasks from one process at a time.
module slq_ctrl_model (
  input wire logic clk_sys,
  output logic [slq_pkg::ADDR_W-1:0] addr,
  output logic [slq_pkg::DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [slq_pkg::DATA_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // ==========================================================================
  // Access tasks
  // Each write carries one keyword and at most one value. Order entries
  // go only through the order register; no legacy order command exists.
  task automatic wr_reg(input logic [slq_pkg::ADDR_W-1:0] a,
                        input logic [slq_pkg::DATA_W-1:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    // Released data is inverted so a late sample cannot pass by luck.
    wdata <= ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [slq_pkg::ADDR_W-1:0] a,
                        output logic [slq_pkg::DATA_W-1:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : slq_ctrl_model

// ==== setpoint_list_sequencer_tb.sv ====
// Self-checking bench for the setpoint list sequencer.
// Assumes the controller model drives the register port.
module setpoint_list_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys;
  logic rst;
  logic [slq_pkg::ADDR_W-1:0] addr;
  logic [slq_pkg::DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [slq_pkg::DATA_W-1:0] rdata;
  logic [slq_pkg::SP_W-1:0] out_setpoint;
  logic out_is_current;
  logic out_enable;
  logic list_running;
  logic oper_summary;
  logic ques_summary;
  logic [slq_pkg::DATA_W-1:0] rv;
  logic [slq_pkg::SP_W-1:0] held;
  logic [15:0] steps;
  int bad_count = 0;
  int cmp_count = 0;

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  slq_sequencer dut (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .out_setpoint(out_setpoint), .out_is_current(out_is_current),
    .out_enable(out_enable), .list_running(list_running),
    .oper_summary(oper_summary), .ques_summary(ques_summary));

  slq_ctrl_model ctl (.clk_sys(clk_sys), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));

  // ==========================================================================
  // Checks and helpers
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit

  task automatic chk_reg(input logic [3:0] a, input logic [15:0] exp);
    ctl.rd_reg(a, rv);
    chk_word(rv, exp);
  endtask : chk_reg

  // Bounded wait for the running flag to reach a level.
  task automatic wait_run(input logic lvl, input int limit);
    int n;
    n = 0;
    while (list_running !== lvl && n < limit)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= limit)
    begin
      bad_count++;
      $display("unexpected at %0t: running flag wait timed out", $time);
      complete_run();
    end
  endtask : wait_run

  task automatic send_cmd(input logic [3:0] c);
    ctl.wr_reg(slq_pkg::ADDR_CMD, {12'h000, c});
  endtask : send_cmd

  // Counts setpoint changes from a start value until the run stops.
  task automatic count_steps(input logic [15:0] from, input int limit);
    int n;
    n = 0;
    steps = 16'h0000;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
      if (out_setpoint !== from)
      begin
        steps++;
        from = out_setpoint;
      end
    end
    while (list_running === 1'b1 && n < limit);
    if (n >= limit)
    begin
      bad_count++;
      $display("unexpected at %0t: step watch timed out", $time);
      complete_run();
    end
  endtask : count_steps

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Scenarios
  initial
  begin
    rst = 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk_reg(slq_pkg::ADDR_COUNT, 16'h0001);
    chk_reg(slq_pkg::ADDR_LIST_VOLT, 16'h0000);
    // Voltage entries only, and one dwell for all of them.
    ctl.wr_reg(slq_pkg::ADDR_LIST_VOLT, 16'h1111);
    ctl.wr_reg(slq_pkg::ADDR_LIST_VOLT, 16'h2222);
    ctl.wr_reg(slq_pkg::ADDR_LIST_VOLT, 16'h3333);
    ctl.wr_reg(slq_pkg::ADDR_DWELL, 16'h0001);
    chk_reg(slq_pkg::ADDR_LIST_VOLT, 16'h0003);
    chk_reg(slq_pkg::ADDR_DWELL, 16'h0001);
    // Two forward passes; edits during the run are refused.
    ctl.wr_reg(slq_pkg::ADDR_OPER_ENAB, 16'h0001);
    ctl.wr_reg(slq_pkg::ADDR_QUES_ENAB, 16'h0080);
    ctl.wr_reg(slq_pkg::ADDR_COUNT, 16'h0002);
    send_cmd(slq_pkg::CMD_LIST_VOLT);
    wait_run(1'b1, 20);
    ctl.wr_reg(slq_pkg::ADDR_LIST_VOLT, 16'h4444);
    send_cmd(slq_pkg::CMD_CLEAR);
    chk_reg(slq_pkg::ADDR_LIST_VOLT, 16'h0003);
    chk_bit(oper_summary, 1'b1);
    chk_bit(ques_summary, 1'b1);
    ctl.rd_reg(slq_pkg::ADDR_QUES_EVT, rv);
    chk_bit(rv[7], 1'b1);
    chk_bit(ques_summary, 1'b0);
    wait_run(1'b0, 2000);
    chk_word(out_setpoint, 16'h3333);
    chk_bit(out_is_current, 1'b0);
    chk_reg(slq_pkg::ADDR_CMD, 16'h0000);
    // Reverse playback ends on the first stored entry.
    ctl.wr_reg(slq_pkg::ADDR_DIR, 16'h0001);
    ctl.wr_reg(slq_pkg::ADDR_COUNT, 16'h0001);
    send_cmd(slq_pkg::CMD_LIST_VOLT);
    wait_run(1'b1, 20);
    wait_run(1'b0, 1000);
    chk_word(out_setpoint, 16'h1111);
    // Endless run, halted by a fixed-mode command; the entry is held.
    ctl.wr_reg(slq_pkg::ADDR_COUNT, 16'h0000);
    send_cmd(slq_pkg::CMD_LIST_VOLT);
    wait_run(1'b1, 20);
    repeat (1500) @(posedge clk_sys);
    #1;
    chk_bit(list_running, 1'b1);
    send_cmd(slq_pkg::CMD_FIX_VOLT);
    #1;
    held = out_setpoint;
    chk_bit(list_running, 1'b0);
    chk_bit(held == 16'h1111 || held == 16'h2222 || held == 16'h3333,
      1'b1);
    repeat (100) @(posedge clk_sys);
    #1;
    chk_word(out_setpoint, held);
    chk_reg(slq_pkg::ADDR_LIST_VOLT, 16'h0003);
    // Output on, then a device reset stops a current-mode run.
    send_cmd(slq_pkg::CMD_OUT_ON);
    #1;
    chk_bit(out_enable, 1'b1);
    send_cmd(slq_pkg::CMD_LIST_CURR);
    wait_run(1'b1, 20);
    #1;
    chk_bit(out_is_current, 1'b1);
    send_cmd(slq_pkg::CMD_RESET);
    #1;
    chk_bit(list_running, 1'b0);
    chk_bit(out_enable, 1'b0);
    chk_bit(out_is_current, 1'b0);
    // Fixed current mode while idle, then output on and off again.
    send_cmd(slq_pkg::CMD_FIX_CURR);
    send_cmd(slq_pkg::CMD_OUT_ON);
    send_cmd(slq_pkg::CMD_OUT_OFF);
    #1;
    chk_bit(out_is_current, 1'b1);
    chk_bit(out_enable, 1'b0);
    // Terminators: a second one right after the first is ignored.
    ctl.wr_reg(slq_pkg::ADDR_TERM, 16'h0041);
    ctl.wr_reg(slq_pkg::ADDR_TERM, {8'h00, slq_pkg::CHAR_CR});
    ctl.wr_reg(slq_pkg::ADDR_TERM, {8'h00, slq_pkg::CHAR_LF});
    ctl.wr_reg(slq_pkg::ADDR_TERM, 16'h0042);
    ctl.wr_reg(slq_pkg::ADDR_TERM, {8'h00, slq_pkg::CHAR_LF});
    chk_reg(slq_pkg::ADDR_TERM, 16'h0002);
    // Clearing empties the list.
    send_cmd(slq_pkg::CMD_CLEAR);
    chk_reg(slq_pkg::ADDR_LIST_VOLT, 16'h0000);
    // Own order 2,0,2,1 over two passes with one skipped step: the
    // second pass plays 0,2,1, so seven setpoint steps are seen.
    ctl.wr_reg(slq_pkg::ADDR_LIST_VOLT, 16'h5555);
    ctl.wr_reg(slq_pkg::ADDR_LIST_VOLT, 16'h6666);
    ctl.wr_reg(slq_pkg::ADDR_LIST_VOLT, 16'h7777);
    ctl.wr_reg(slq_pkg::ADDR_DWELL, 16'h0001);
    ctl.wr_reg(slq_pkg::ADDR_ORDER, 16'h0002);
    ctl.wr_reg(slq_pkg::ADDR_ORDER, 16'h0000);
    ctl.wr_reg(slq_pkg::ADDR_ORDER, 16'h0002);
    ctl.wr_reg(slq_pkg::ADDR_ORDER, 16'h0001);
    ctl.wr_reg(slq_pkg::ADDR_DIR, 16'h0000);
    ctl.wr_reg(slq_pkg::ADDR_SKIP, 16'h0001);
    ctl.wr_reg(slq_pkg::ADDR_COUNT, 16'h0002);
    chk_reg(slq_pkg::ADDR_ORDER, 16'h0004);
    held = out_setpoint;
    send_cmd(slq_pkg::CMD_LIST_VOLT);
    count_steps(held, 1000);
    chk_word(steps, 16'h0007);
    chk_word(out_setpoint, 16'h6666);
    complete_run();
  end
endmodule : setpoint_list_sequencer_tb
